// >>> crypto_host_pkg.sv
// Shared constants, types and pin bundles for the encryption module host control
package crypto_host_pkg;

    // Link byte width and bit counter width
    localparam int SPI_BITS = 8;
    localparam int BIT_W = 3;

    // Timing: system clock and serial clock half period (least time, round up)
    localparam int CLK_PERIOD_NS = 25;
    localparam int SPI_HALF_NS = 100;
    localparam int SPI_HALF_CYC = (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 3;

    // Target encoding for the slave select choice
    localparam logic TARGET_CRYPTO = 1'b0;
    localparam logic TARGET_RTC = 1'b1;

    // Reset values of the pin-facing registers
    localparam logic BOOT_RESET = 1'b1;
    localparam logic MODULE_RESET_N_RESET = 1'b0;
    localparam logic SS_N_RESET = 1'b1;

    // Serial link engine states
    typedef enum logic [3:0] {
        SPI_IDLE = 4'b0001,
        SPI_LOW = 4'b0010,
        SPI_HIGH = 4'b0100,
        SPI_TAIL = 4'b1000
    } spi_state_t;

    // Inputs that arrive from outside the clock domain
    typedef struct packed {
        logic miso;
        logic service_req;
        logic erase_n;
        logic keyfail_n;
        logic async_tx;
        logic tamper_switch;
        logic supply_ok;
    } pin_in_t;

    // Quiet level of the pin inputs, used as the synchroniser reset value
    localparam pin_in_t PIN_IDLE = '{miso: 1'b0, service_req: 1'b0, erase_n: 1'b1, keyfail_n: 1'b1,
                                     async_tx: 1'b1, tamper_switch: 1'b0, supply_ok: 1'b1};

endpackage

// >>> spi_byte_master.sv
// Byte-wide serial link master with clock divider and two slave selects
`timescale 1ns/1ps
`default_nettype none

module spi_byte_master (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic target,
    input wire logic [7:0] tx_byte,
    input wire logic miso,
    output logic sclk,
    output logic mosi,
    output logic crypto_ss_n,
    output logic rtc_ss_n,
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte
);
    localparam logic [crypto_host_pkg::DIV_W-1:0] HALF_M1 =
        crypto_host_pkg::DIV_W'(crypto_host_pkg::SPI_HALF_CYC - 1);
    localparam logic [crypto_host_pkg::BIT_W-1:0] LAST_BIT =
        crypto_host_pkg::BIT_W'(crypto_host_pkg::SPI_BITS - 1);

    crypto_host_pkg::spi_state_t state_reg, state_next;
    logic [crypto_host_pkg::DIV_W-1:0] div_reg, div_next;
    logic [crypto_host_pkg::BIT_W-1:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next, rx_reg, rx_next;
    logic sclk_reg, sclk_next, mosi_reg, mosi_next, css_reg, css_next, rss_reg, rss_next;
    logic busy_reg, busy_next, done_reg, done_next;

    // Next state of the shift engine
    always_comb begin
        state_next = state_reg;
        div_next = div_reg + 1'b1;
        bit_next = bit_reg;
        shift_next = shift_reg;
        rx_next = rx_reg;
        sclk_next = sclk_reg;
        mosi_next = mosi_reg;
        css_next = css_reg;
        rss_next = rss_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        case (state_reg)
            crypto_host_pkg::SPI_IDLE: begin
                div_next = '0;
                if (start) begin
                    // Select first, data bit ready before the first rise
                    css_next = target;
                    rss_next = ~target;
                    shift_next = tx_byte;
                    mosi_next = tx_byte[7];
                    bit_next = '0;
                    busy_next = 1'b1;
                    state_next = crypto_host_pkg::SPI_LOW;
                end
            end
            crypto_host_pkg::SPI_LOW: begin
                if (div_reg == HALF_M1) begin
                    // Rise: sample the slave bit into the vacated end
                    div_next = '0;
                    sclk_next = 1'b1;
                    shift_next = {shift_reg[6:0], miso};
                    state_next = crypto_host_pkg::SPI_HIGH;
                end
            end
            crypto_host_pkg::SPI_HIGH: begin
                if (div_reg == HALF_M1) begin
                    div_next = '0;
                    sclk_next = 1'b0;
                    if (bit_reg == LAST_BIT) begin
                        state_next = crypto_host_pkg::SPI_TAIL;
                    end else begin
                        bit_next = bit_reg + 1'b1;
                        mosi_next = shift_reg[7];
                        state_next = crypto_host_pkg::SPI_LOW;
                    end
                end
            end
            crypto_host_pkg::SPI_TAIL: begin
                // Hold select one half period past the last fall
                if (div_reg == HALF_M1) begin
                    css_next = 1'b1;
                    rss_next = 1'b1;
                    rx_next = shift_reg;
                    done_next = 1'b1;
                    busy_next = 1'b0;
                    state_next = crypto_host_pkg::SPI_IDLE;
                end
            end
            default: begin
                state_next = crypto_host_pkg::SPI_IDLE;
                css_next = 1'b1;
                rss_next = 1'b1;
                sclk_next = 1'b0;
                busy_next = 1'b0;
            end
        endcase
    end

    // Engine registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= crypto_host_pkg::SPI_IDLE;
            div_reg <= '0;
            bit_reg <= '0;
            shift_reg <= '0;
            rx_reg <= '0;
            sclk_reg <= 1'b0;
            mosi_reg <= 1'b0;
            css_reg <= crypto_host_pkg::SS_N_RESET;
            rss_reg <= crypto_host_pkg::SS_N_RESET;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            rx_reg <= rx_next;
            sclk_reg <= sclk_next;
            mosi_reg <= mosi_next;
            css_reg <= css_next;
            rss_reg <= rss_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign sclk = sclk_reg;
    assign mosi = mosi_reg;
    assign crypto_ss_n = css_reg;
    assign rtc_ss_n = rss_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign rx_byte = rx_reg;

    // Checking helper: rising serial clock edges within the current frame
    logic [3:0] rise_cnt_reg, rise_cnt_next;
    always_comb begin
        rise_cnt_next = rise_cnt_reg;
        if (state_reg == crypto_host_pkg::SPI_IDLE && start) begin
            rise_cnt_next = '0;
        end else if (!sclk_reg && sclk_next) begin
            rise_cnt_next = rise_cnt_reg + 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_cnt_reg <= '0;
        end else begin
            rise_cnt_reg <= rise_cnt_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_BYTE_EIGHT_EDGES: assert property (done |-> rise_cnt_reg == 4'h8)
        else $error("Frame ended without exactly eight clock rises");
    AST_ONE_SLAVE: assert property (!(!crypto_ss_n && !rtc_ss_n))
        else $error("Both slave selects active together");
    AST_START_SELECT: assert property ((state_reg == crypto_host_pkg::SPI_IDLE && start && !target)
        |=> !crypto_ss_n && !sclk && mosi == $past(tx_byte[7]))
        else $error("Start did not select the module with the first bit ready");
    AST_SS_WHOLE_FRAME: assert property (busy |-> !(crypto_ss_n && rtc_ss_n))
        else $error("Select released inside a frame");
    AST_CLOCK_QUIET: assert property (crypto_ss_n && rtc_ss_n |-> !sclk)
        else $error("Serial clock high with no slave selected");
    AST_SELECT_DROP: assert property ($rose(crypto_ss_n) |-> done && !sclk && $past(!sclk, 4))
        else $error("Select released before the last clock fall settled");

    COV_CRYPTO_BYTE: cover property (done && $past(!crypto_ss_n));
    COV_RTC_BYTE: cover property (done && $past(!rtc_ss_n));
    COV_BACK_TO_BACK: cover property (done ##1 start ##1 busy);

endmodule

`default_nettype wire

// >>> crypto_module_host_control.sv
// Host-side control and link logic for the external encryption module
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Byte exchanged both ways per transfer
// - Host always masters clock and selects
// - Select, then shift out and in together
// - Module select active low during exchanges only
// - Boot line level during reset picks mode
// - Wakeup line brings module out of sleep
// - Module reset from system, software, direct
// - Tamper or supply drop activates tamper line
// - Erase line resets module, key kept
// - Async serial path: transmit and receive lines
// - Open-collector key/fail line, drive and sense
module crypto_module_host_control (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic xfer_start,
    input wire logic xfer_target,
    input wire logic [7:0] xfer_tx_byte,
    output logic xfer_busy,
    output logic xfer_done,
    output logic [7:0] xfer_rx_byte,
    input wire logic sw_reset_req,
    input wire logic direct_reset_req,
    input wire logic boot_production,
    input wire logic wakeup_req,
    input wire logic keyfail_drive_low,
    input wire logic host_async_tx,
    output logic host_async_rx,
    output logic service_irq,
    output logic keyfail_sense,
    output logic tamper_active,
    output logic erase_active,
    output logic spi_clk,
    output logic spi_mosi,
    input wire logic spi_miso,
    output logic crypto_ss_n,
    output logic rtc_ss_n,
    output logic crypto_boot_n,
    output logic crypto_wakeup,
    output logic crypto_reset_n,
    output logic crypto_async_rx,
    input wire logic crypto_async_tx,
    input wire logic crypto_service_request,
    input wire logic crypto_keyfail_n_in,
    output logic crypto_keyfail_n_out,
    output logic crypto_keyfail_n_oe,
    input wire logic tamper_switch,
    input wire logic controlled_low_supply_ok,
    input wire logic crypto_erase_n,
    output logic crypto_tamper_n
);
    crypto_host_pkg::pin_in_t pins_raw, sync1_reg, sync1_next, sync2_reg, sync2_next;

    // Two-stage synchroniser for every pin input; only stage two is read
    always_comb begin
        pins_raw.miso = spi_miso;
        pins_raw.service_req = crypto_service_request;
        pins_raw.erase_n = crypto_erase_n;
        pins_raw.keyfail_n = crypto_keyfail_n_in;
        pins_raw.async_tx = crypto_async_tx;
        pins_raw.tamper_switch = tamper_switch;
        pins_raw.supply_ok = controlled_low_supply_ok;
        sync1_next = pins_raw;
        sync2_next = sync1_reg;
    end

    // Synchroniser stages start at the quiet pin levels so no false event follows reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= crypto_host_pkg::PIN_IDLE;
            sync2_reg <= crypto_host_pkg::PIN_IDLE;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // Byte link engine; miso enters already synchronised
    spi_byte_master u_spi (
        .clk(clk),
        .rst_b(rst_b),
        .start(xfer_start),
        .target(xfer_target),
        .tx_byte(xfer_tx_byte),
        .miso(sync2_reg.miso),
        .sclk(spi_clk),
        .mosi(spi_mosi),
        .crypto_ss_n(crypto_ss_n),
        .rtc_ss_n(rtc_ss_n),
        .busy(xfer_busy),
        .done(xfer_done),
        .rx_byte(xfer_rx_byte)
    );

    logic reset_n_reg, reset_n_next, boot_n_reg, boot_n_next, wake_reg, wake_next;
    logic tamper_n_reg, tamper_n_next, erase_reg, erase_next, tamper_act_reg, tamper_act_next;
    logic async_out_reg, async_out_next, async_in_reg, async_in_next, irq_reg, irq_next;
    logic kf_oe_reg, kf_oe_next, kf_out_reg, kf_out_next, kf_sense_reg, kf_sense_next;

    // Module control lines
    always_comb begin
        // Erase joins the reset, never the tamper line, so the key survives it
        erase_next = ~sync2_reg.erase_n;
        reset_n_next = ~(sw_reset_req | direct_reset_req | erase_next);
        // Boot level follows the selection only while the module sits in reset
        boot_n_next = reset_n_reg ? boot_n_reg : boot_production;
        wake_next = wakeup_req;
        // Tamper needs no host help; the module clears its own key on it
        tamper_n_next = ~(sync2_reg.tamper_switch | ~sync2_reg.supply_ok);
        // Own flop for the flag, so the output is a register rather than an inverter
        tamper_act_next = ~tamper_n_next;
        async_out_next = host_async_tx;
        async_in_next = sync2_reg.async_tx;
        irq_next = sync2_reg.service_req;
        // Open-collector: only ever pulls low, sensing reads the wired level
        kf_oe_next = keyfail_drive_low;
        kf_out_next = 1'b0;
        kf_sense_next = ~sync2_reg.keyfail_n;
    end

    // Control line registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // System reset holds the module in reset as well
            reset_n_reg <= crypto_host_pkg::MODULE_RESET_N_RESET;
            boot_n_reg <= crypto_host_pkg::BOOT_RESET;
            wake_reg <= 1'b0;
            tamper_n_reg <= 1'b1;
            tamper_act_reg <= 1'b0;
            erase_reg <= 1'b0;
            async_out_reg <= 1'b1;
            async_in_reg <= 1'b1;
            irq_reg <= 1'b0;
            kf_oe_reg <= 1'b0;
            kf_out_reg <= 1'b0;
            kf_sense_reg <= 1'b0;
        end else begin
            reset_n_reg <= reset_n_next;
            boot_n_reg <= boot_n_next;
            wake_reg <= wake_next;
            tamper_n_reg <= tamper_n_next;
            tamper_act_reg <= tamper_act_next;
            erase_reg <= erase_next;
            async_out_reg <= async_out_next;
            async_in_reg <= async_in_next;
            irq_reg <= irq_next;
            kf_oe_reg <= kf_oe_next;
            kf_out_reg <= kf_out_next;
            kf_sense_reg <= kf_sense_next;
        end
    end

    // Every output leaves straight from its own flop
    assign crypto_reset_n = reset_n_reg;
    assign crypto_boot_n = boot_n_reg;
    assign crypto_wakeup = wake_reg;
    assign crypto_tamper_n = tamper_n_reg;
    assign erase_active = erase_reg;
    assign tamper_active = tamper_act_reg;
    assign crypto_async_rx = async_out_reg;
    assign host_async_rx = async_in_reg;
    assign service_irq = irq_reg;
    assign crypto_keyfail_n_oe = kf_oe_reg;
    assign crypto_keyfail_n_out = kf_out_reg;
    assign keyfail_sense = kf_sense_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_SW_RESET: assert property (sw_reset_req |=> !crypto_reset_n)
        else $error("Software reset did not reset the module");
    AST_DIRECT_RESET: assert property (direct_reset_req |=> !crypto_reset_n)
        else $error("Direct reset did not reset the module");
    AST_RESET_RELEASE: assert property (!sw_reset_req && !direct_reset_req && crypto_erase_n [*3]
        |=> crypto_reset_n)
        else $error("Module reset held with no source active");
    AST_ERASE_RESET: assert property (!crypto_erase_n [*3] |=> !crypto_reset_n && erase_active)
        else $error("Erase did not reset the module");
    AST_ERASE_KEEPS_KEY: assert property (!crypto_erase_n && !tamper_switch && controlled_low_supply_ok [*3]
        |=> crypto_tamper_n)
        else $error("Erase disturbed the tamper line");
    AST_TAMPER_SWITCH: assert property (tamper_switch [*3] |=> !crypto_tamper_n)
        else $error("Tamper switch did not activate the tamper line");
    AST_SUPPLY_DROP: assert property (!controlled_low_supply_ok [*3] |=> !crypto_tamper_n)
        else $error("Supply drop did not activate the tamper line");
    AST_BOOT_SAMPLE: assert property (!crypto_reset_n |=> crypto_boot_n == $past(boot_production))
        else $error("Boot line not following selection during reset");
    AST_BOOT_HOLD: assert property (crypto_reset_n |=> $stable(crypto_boot_n))
        else $error("Boot line moved outside module reset");
    AST_WAKEUP: assert property (wakeup_req |=> crypto_wakeup)
        else $error("Wakeup request not driven to the module");
    AST_ASYNC_PATH: assert property (crypto_async_tx [*3] |=> host_async_rx ##0
        crypto_async_rx == $past(host_async_tx))
        else $error("Async serial path broken");
    AST_KEYFAIL_OC: assert property (keyfail_drive_low |=> crypto_keyfail_n_oe && !crypto_keyfail_n_out)
        else $error("Key/fail line not pulled low when asked");
    AST_SERVICE_IRQ: assert property (crypto_service_request [*3] |=> service_irq)
        else $error("Service request did not reach the interrupt");

    // Release side of the level paths; a line stuck active would pass the checks above
    AST_TAMPER_CLEAR: assert property ((!tamper_switch && controlled_low_supply_ok) [*3] |=> crypto_tamper_n)
        else $error("Tamper line stayed active with no cause");
    AST_ERASE_CLEAR: assert property (crypto_erase_n [*3] |=> !erase_active)
        else $error("Erase flag stayed set after the line returned high");
    AST_WAKE_DROP: assert property (!wakeup_req |=> !crypto_wakeup)
        else $error("Wakeup line held with no request");
    AST_KEYFAIL_FREE: assert property (!keyfail_drive_low |=> !crypto_keyfail_n_oe)
        else $error("Key/fail line driven with no request");
    AST_KEYFAIL_SENSE: assert property (!crypto_keyfail_n_in [*3] |=> keyfail_sense)
        else $error("Low key/fail line not sensed");
    AST_ASYNC_LOW: assert property (!crypto_async_tx [*3] |=> !host_async_rx)
        else $error("Async receive line stuck high");

    COV_TAMPER: cover property ($fell(crypto_tamper_n));
    COV_ERASE_RESET: cover property ($rose(erase_active) ##1 !crypto_reset_n);
    COV_BOOTSTRAP: cover property (!crypto_reset_n && !boot_production ##1 crypto_reset_n && !crypto_boot_n);

endmodule

`default_nettype wire

// >>> crypto_slave_model.sv
// Behavioural encryption module on the far side: serial slave, key store, async echo
`timescale 1ns/1ps
`default_nettype none

module crypto_slave_model (
    input wire logic spi_clk,
    input wire logic spi_mosi,
    input wire logic crypto_ss_n,
    input wire logic crypto_tamper_n,
    input wire logic crypto_async_rx,
    input wire logic req_in,
    input wire logic [7:0] reply,
    output logic spi_miso,
    output logic crypto_async_tx,
    output logic crypto_service_request,
    output logic [7:0] got_byte,
    output logic key_kept
);
    logic [7:0] sh_reg;

    // Start-up contents
    initial begin
        spi_miso = 1'b0;
        got_byte = 8'h00;
        key_kept = 1'b1;
        sh_reg = 8'h00;
    end

    // Load reply on select; a released line flips so a stale bit never looks valid
    always @(crypto_ss_n) begin
        if (crypto_ss_n === 1'b0) begin
            sh_reg = reply;
            spi_miso = reply[7];
        end else begin
            spi_miso = ~spi_miso;
        end
    end

    // Take master bit on rise, present next bit on fall
    always @(posedge spi_clk) if (crypto_ss_n === 1'b0) got_byte = {got_byte[6:0], spi_mosi};
    always @(negedge spi_clk) begin
        if (crypto_ss_n === 1'b0) begin
            sh_reg = {sh_reg[6:0], 1'b0};
            spi_miso = sh_reg[7];
        end
    end

    // Key wiped on tamper only; a plain reset leaves it alone
    always @(negedge crypto_tamper_n) key_kept = 1'b0;

    // Serial input echoed straight back, request driven by the bench
    assign crypto_async_tx = crypto_async_rx;
    assign crypto_service_request = req_in;
endmodule

`default_nettype wire

// >>> test_crypto_module_host_control.sv
// Self-checking bench for the encryption module host control block
`timescale 1ns/1ps
`default_nettype none

module test_crypto_module_host_control;
    typedef struct packed {logic chk; logic [7:0] rx; logic [7:0] tx;} exp_t;
    logic clk = 1'b0, rst_b = 1'b0, xfer_start = 1'b0, xfer_target = 1'b0;
    logic [7:0] xfer_tx_byte = 8'h00, reply = 8'h00, xfer_rx_byte, got_byte;
    logic sw_reset_req = 1'b0, direct_reset_req = 1'b0, boot_production = 1'b1, wakeup_req = 1'b0;
    logic keyfail_drive_low = 1'b0, host_async_tx = 1'b1, tamper_switch = 1'b0, svc_req = 1'b0;
    logic controlled_low_supply_ok = 1'b1, crypto_erase_n = 1'b1, rst_exp, boot_exp, key_exp;
    logic xfer_busy, xfer_done, host_async_rx, service_irq, keyfail_sense, tamper_active, erase_active;
    logic spi_clk, spi_mosi, spi_miso, crypto_ss_n, rtc_ss_n, crypto_boot_n, crypto_wakeup, crypto_reset_n;
    logic crypto_async_rx, crypto_async_tx, crypto_service_request, crypto_keyfail_n_out;
    logic crypto_keyfail_n_oe, crypto_tamper_n, key_kept;
    int error_cnt = 0, n_tests = 0, seed, bits = 0;
    exp_t expq[$];
    exp_t mon_e;
    // Key/fail line pulled up unless the block drives it
    wire logic crypto_keyfail_n_in = crypto_keyfail_n_oe ? crypto_keyfail_n_out : 1'b1;
    wire logic both_hi = crypto_ss_n & rtc_ss_n;

    crypto_module_host_control DUT (.clk, .rst_b, .xfer_start, .xfer_target, .xfer_tx_byte, .xfer_busy,
        .xfer_done, .xfer_rx_byte, .sw_reset_req, .direct_reset_req, .boot_production, .wakeup_req,
        .keyfail_drive_low, .host_async_tx, .host_async_rx, .service_irq, .keyfail_sense, .tamper_active,
        .erase_active, .spi_clk, .spi_mosi, .spi_miso, .crypto_ss_n, .rtc_ss_n, .crypto_boot_n,
        .crypto_wakeup, .crypto_reset_n, .crypto_async_rx, .crypto_async_tx, .crypto_service_request,
        .crypto_keyfail_n_in, .crypto_keyfail_n_out, .crypto_keyfail_n_oe, .tamper_switch,
        .controlled_low_supply_ok, .crypto_erase_n, .crypto_tamper_n);

    crypto_slave_model slave (.spi_clk, .spi_mosi, .crypto_ss_n, .crypto_tamper_n, .crypto_async_rx,
        .req_in(svc_req), .reply, .spi_miso, .crypto_async_tx, .crypto_service_request, .got_byte, .key_kept);

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        check8(what, {7'h00, exp}, {7'h00, got});
    endtask

    function automatic logic rb(input int m);
        return ($random(seed) & (m - 1)) == 0;
    endfunction

    // Bounded wait for the busy flag, looked at mid-cycle where it has settled
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i <= 200; i++) begin
            @(negedge clk);
            if (xfer_busy === lvl) return;
        end
        error_cnt++;
        $display("mismatch busy wait expected %b seen timeout", lvl);
        report_and_stop();
    endtask

    // Start stays high so the next byte is taken in the done cycle
    task automatic xfer(input logic tgt, input logic [7:0] tx, input logic [7:0] rep);
        @(posedge clk);
        xfer_start <= 1'b1;
        xfer_target <= tgt;
        xfer_tx_byte <= tx;
        reply <= rep;
        expq.push_back('{~tgt, rep, tx});
        wait_busy(1'b0);
        wait_busy(1'b1);
    endtask

    // Result watcher: oldest note against each done pulse
    always @(negedge clk) begin
        if (xfer_done === 1'b1) begin
            if (expq.size() == 0) begin
                check8("done without request", 8'h00, 8'h01);
            end else begin
                mon_e = expq.pop_front();
                if (mon_e.chk) check8("rx byte", mon_e.rx, xfer_rx_byte);
                if (mon_e.chk) check8("slave byte", mon_e.tx, got_byte);
            end
        end
    end

    // Exactly one select low at every serial clock rise
    always @(posedge spi_clk) begin
        bits++;
        check1("one select low", 1'b1, crypto_ss_n ^ rtc_ss_n);
    end

    // Whole byte clocked before the select lets go
    always @(posedge both_hi) begin
        if (bits != 0) check8("edges per select", 8'h08, 8'(bits));
        bits = 0;
    end

    // Main sequence
    initial begin
        seed = 6522;
        boot_exp = 1'b1;
        key_exp = 1'b1;
        repeat (10) @(posedge clk);
        check1("reset held", 1'b0, crypto_reset_n);
        check1("select idle", 1'b1, crypto_ss_n);
        check1("boot idle", 1'b1, crypto_boot_n);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        // Back-to-back bytes, every fourth to the time chip
        for (int i = 0; i < 12; i++) xfer(i[1:0] == 2'b11, 8'($random(seed)), 8'($random(seed)));
        @(posedge clk);
        xfer_start <= 1'b0;
        wait_busy(1'b0);
        // Let the watcher take the last note before counting what is left
        @(posedge clk);
        check8("pending results", 8'h00, 8'(expq.size()));
        // Random control and pin levels, checked once settled
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            sw_reset_req <= rb(4);
            direct_reset_req <= rb(4);
            crypto_erase_n <= !rb(4);
            tamper_switch <= rb(16);
            controlled_low_supply_ok <= !rb(16);
            wakeup_req <= rb(2);
            keyfail_drive_low <= rb(2);
            host_async_tx <= rb(2);
            svc_req <= rb(2);
            repeat (6) @(posedge clk);
            rst_exp = ~(sw_reset_req | direct_reset_req | ~crypto_erase_n);
            key_exp = key_exp & controlled_low_supply_ok & ~tamper_switch;
            check1("module reset", rst_exp, crypto_reset_n);
            check1("erase flag", ~crypto_erase_n, erase_active);
            check1("tamper line", controlled_low_supply_ok & ~tamper_switch, crypto_tamper_n);
            check1("tamper flag", ~controlled_low_supply_ok | tamper_switch, tamper_active);
            check1("key kept", key_exp, key_kept);
            check1("wakeup", wakeup_req, crypto_wakeup);
            check1("async out", host_async_tx, crypto_async_rx);
            check1("async in", host_async_tx, host_async_rx);
            check1("service irq", svc_req, service_irq);
            check1("keyfail drive", keyfail_drive_low, crypto_keyfail_n_oe);
            check1("keyfail out", 1'b0, crypto_keyfail_n_out);
            check1("keyfail sense", keyfail_drive_low, keyfail_sense);
            // Boot level follows only while the module is held in reset
            @(posedge clk);
            boot_production <= rb(2);
            repeat (3) @(posedge clk);
            if (!rst_exp) boot_exp = boot_production;
            check1("boot line", boot_exp, crypto_boot_n);
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
